//--- rtl/adc_link_pkg.sv
package adc_link_pkg;

	// Bus address: fixed upper bits, low two bits from the strap
	localparam logic [4:0] ADDR_BASE     = 5'h12;
	localparam logic [1:0] STRAP_GROUND  = 2'h0;
	localparam logic [1:0] STRAP_SUPPLY  = 2'h1;
	localparam logic [1:0] STRAP_DATA    = 2'h2;
	localparam logic [1:0] STRAP_CLOCK   = 2'h3;

	// Pointer codes
	localparam logic [1:0] PTR_CONV      = 2'h0;
	localparam logic [1:0] PTR_CONFIG    = 2'h1;
	localparam logic [1:0] PTR_LO_THRESH = 2'h2;
	localparam logic [1:0] PTR_HI_THRESH = 2'h3;

	// Values after reset
	localparam logic [15:0] CONFIG_RESET = 16'h8583;
	localparam logic [15:0] LO_RESET     = 16'h8000;
	localparam logic [15:0] HI_RESET     = 16'h7FFF;

	// Config fields
	localparam int CFG_START_BIT = 15;
	localparam int CFG_SEL_LSB   = 12;
	localparam int CFG_MODE_BIT  = 8;

	// Bits per byte, counted on rising clock edges
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef struct packed {
		logic scl;
		logic sda;
		logic addr_sel;
	} pins_t;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0000,
		ST_ADDR   = 4'b0001,
		ST_A_ACK  = 4'b0010,
		ST_PTR    = 4'b0011,
		ST_P_ACK  = 4'b0100,
		ST_WDATA  = 4'b0101,
		ST_W_ACK  = 4'b0110,
		ST_RDATA  = 4'b0111,
		ST_R_ACK  = 4'b1000,
		ST_IGNORE = 4'b1001
	} link_state_t;

	typedef enum logic [1:0] {
		NEG_GROUND = 2'b00,
		NEG_SECOND = 2'b01,
		NEG_FOURTH = 2'b10
	} neg_sel_t;

	// pos_sel bit 0 is first_analog_input .. bit 3 fourth_analog_input
	typedef struct packed {
		logic [3:0] pos_sel;
		neg_sel_t   neg;
	} route_t;

	function automatic route_t decode_route(input logic [2:0] input_select_field);
		route_t r;
		r.pos_sel = 4'h0;
		r.neg     = NEG_GROUND;
		unique case (input_select_field)
			3'h0: begin
				r.pos_sel = 4'h1;
				r.neg     = NEG_SECOND;
			end
			3'h1: begin
				r.pos_sel = 4'h1;
				r.neg     = NEG_FOURTH;
			end
			3'h2: begin
				r.pos_sel = 4'h2;
				r.neg     = NEG_FOURTH;
			end
			3'h3: begin
				r.pos_sel = 4'h4;
				r.neg     = NEG_FOURTH;
			end
			3'h4: r.pos_sel = 4'h1;
			3'h5: r.pos_sel = 4'h2;
			3'h6: r.pos_sel = 4'h4;
			3'h7: r.pos_sel = 4'h8;
		endcase
		return r;
	endfunction

endpackage

//--- rtl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	initial begin
		if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");
	end

	// Idle bus lines are pulled high, so reset to ones
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			meta_q   <= '1;
			sync_out <= '1;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

`default_nettype wire

//--- rtl/adc_serial_target.sv
`timescale 1ns/1ps
`default_nettype none

module adc_serial_target (
	input  wire logic                 clock,
	input  wire logic                 rst,
	input  wire adc_link_pkg::pins_t  pins,
	output logic                      sda_out,
	output logic                      sda_oe_n,
	input  wire logic [15:0]          conversion_data,
	output logic [15:0]               config_word,
	output logic [15:0]               lo_threshold,
	output logic [15:0]               hi_threshold,
	output logic                      conv_start,
	output adc_link_pkg::route_t      route
);
	import adc_link_pkg::*;

	pins_t       s;
	logic        scl_d_q, sda_d_q;
	logic        scl_rise, scl_fall, start_ev, stop_ev;
	link_state_t st_q;
	logic [3:0]  cnt_q;
	logic [7:0]  sh_q;
	logic [15:0] tx_q;
	logic [7:0]  msb_q;
	logic [1:0]  ptr_q;
	logic        rw_q, widx_q, ridx_q, drv_q;
	logic        wr_q;
	logic [15:0] wdata_q;
	logic        ever1_q, ever0_q, neq_sda_q;
	logic [1:0]  strap;
	logic [6:0]  my_addr;
	logic [15:0] cfg_q, lo_q, hi_q, rd_word;

	// Pins cross into the clock domain first
	pin_sync #(.WIDTH(3)) u_sync (
		.clock    (clock),
		.rst      (rst),
		.async_in (pins),
		.sync_out (s)
	);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			scl_d_q <= 1'b1;
			sda_d_q <= 1'b1;
		end else begin
			scl_d_q <= s.scl;
			sda_d_q <= s.sda;
		end
	end

	// At 10 MHz high-speed traffic is too fast to oversample; limitation of this clock
	assign scl_rise = s.scl && !scl_d_q;
	assign scl_fall = !s.scl && scl_d_q;
	assign start_ev = s.scl && scl_d_q && !s.sda && sda_d_q;
	assign stop_ev  = s.scl && scl_d_q && s.sda && !sda_d_q;

	// Strap seen through the address byte; strap and data share one sync delay
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ever1_q   <= 1'b0;
			ever0_q   <= 1'b0;
			neq_sda_q <= 1'b0;
		end else if (start_ev) begin
			ever1_q   <= 1'b0;
			ever0_q   <= 1'b0;
			neq_sda_q <= 1'b0;
		end else if (st_q == ST_ADDR) begin
			ever1_q   <= ever1_q | s.addr_sel;
			ever0_q   <= ever0_q | !s.addr_sel;
			neq_sda_q <= neq_sda_q | (s.addr_sel != s.sda);
		end
	end

	always_comb begin
		if (!ever1_q) begin
			strap = STRAP_GROUND;
		end else if (!ever0_q) begin
			strap = STRAP_SUPPLY;
		end else if (!neq_sda_q) begin
			strap = STRAP_DATA;
		end else begin
			strap = STRAP_CLOCK;
		end
	end
	assign my_addr = {ADDR_BASE, strap};

	always_comb begin
		unique case (ptr_q)
			PTR_CONV:      rd_word = conversion_data;
			PTR_CONFIG:    rd_word = cfg_q;
			PTR_LO_THRESH: rd_word = lo_q;
			PTR_HI_THRESH: rd_word = hi_q;
		endcase
	end

	// Byte engine: sample on clock rise, change the data line only after a fall
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_q   <= ST_IDLE;
			cnt_q  <= 4'h0;
			sh_q   <= 8'h00;
			tx_q   <= 16'h0000;
			msb_q  <= 8'h00;
			ptr_q  <= PTR_CONV;
			rw_q   <= 1'b0;
			widx_q <= 1'b0;
			ridx_q <= 1'b0;
			drv_q  <= 1'b0;
		end else if (start_ev) begin
			st_q  <= ST_ADDR;
			cnt_q <= 4'h0;
			drv_q <= 1'b0;
		end else if (stop_ev) begin
			st_q  <= ST_IDLE;
			drv_q <= 1'b0;
		end else begin
			unique case (st_q)
				ST_IDLE, ST_IGNORE: begin
				end
				ST_ADDR, ST_PTR, ST_WDATA: begin
					if (scl_rise) begin
						sh_q  <= {sh_q[6:0], s.sda};
						cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
						cnt_q <= 4'h0;
						drv_q <= 1'b1;
						if (st_q == ST_ADDR) begin
							if (sh_q[7:1] == my_addr) begin
								rw_q <= sh_q[0];
								st_q <= ST_A_ACK;
							end else begin
								drv_q <= 1'b0;
								st_q  <= ST_IGNORE;
							end
						end else if (st_q == ST_PTR) begin
							ptr_q <= sh_q[1:0];
							st_q  <= ST_P_ACK;
						end else begin
							st_q <= ST_W_ACK;
						end
					end
				end
				ST_A_ACK: begin
					if (scl_fall) begin
						if (rw_q) begin
							tx_q   <= rd_word;
							drv_q  <= !rd_word[15];
							ridx_q <= 1'b0;
							st_q   <= ST_RDATA;
						end else begin
							drv_q <= 1'b0;
							st_q  <= ST_PTR;
						end
					end
				end
				ST_P_ACK: begin
					if (scl_fall) begin
						drv_q  <= 1'b0;
						widx_q <= 1'b0;
						st_q   <= ST_WDATA;
					end
				end
				ST_W_ACK: begin
					if (scl_fall) begin
						drv_q  <= 1'b0;
						msb_q  <= sh_q;
						widx_q <= !widx_q;
						st_q   <= ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (scl_rise) begin
						cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall) begin
						tx_q <= {tx_q[14:0], 1'b0};
						if (cnt_q == BITS_PER_BYTE) begin
							cnt_q <= 4'h0;
							drv_q <= 1'b0;
							st_q  <= ST_R_ACK;
						end else begin
							drv_q <= !tx_q[14];
						end
					end
				end
				ST_R_ACK: begin
					if (scl_rise && s.sda) begin
						st_q <= ST_IGNORE;
					end else if (scl_fall) begin
						// High byte first, then low byte, then the word again
						if (ridx_q) begin
							tx_q  <= rd_word;
							drv_q <= !rd_word[15];
						end else begin
							drv_q <= !tx_q[15];
						end
						ridx_q <= !ridx_q;
						st_q   <= ST_RDATA;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// Second byte of each data pair commits the word
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_q    <= 1'b0;
			wdata_q <= 16'h0000;
		end else begin
			wr_q    <= (st_q == ST_W_ACK) && scl_fall && widx_q && !start_ev && !stop_ev;
			wdata_q <= {msb_q, sh_q};
		end
	end

	// Conversion result is read only; writes to it are dropped
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cfg_q      <= CONFIG_RESET;
			lo_q       <= LO_RESET;
			hi_q       <= HI_RESET;
			conv_start <= 1'b0;
		end else begin
			conv_start <= 1'b0;
			if (wr_q) begin
				unique case (ptr_q)
					PTR_CONV: begin
					end
					PTR_CONFIG: begin
						cfg_q      <= wdata_q;
						conv_start <= wdata_q[CFG_START_BIT] && wdata_q[CFG_MODE_BIT];
					end
					PTR_LO_THRESH: lo_q <= wdata_q;
					PTR_HI_THRESH: hi_q <= wdata_q;
				endcase
			end
		end
	end

	assign route        = decode_route(cfg_q[CFG_SEL_LSB+2:CFG_SEL_LSB]);
	assign config_word  = cfg_q;
	assign lo_threshold = lo_q;
	assign hi_threshold = hi_q;
	assign sda_out      = 1'b0;
	assign sda_oe_n     = !drv_q;

	drive_on_fall_a: assert property (@(posedge clock) disable iff (rst)
		$changed(drv_q) |-> $past(scl_fall) || $past(start_ev) || $past(stop_ev))
		else $error("data line changed away from a clock fall");
	foreign_addr_a: assert property (@(posedge clock) disable iff (rst)
		(st_q == ST_ADDR && scl_fall && cnt_q == BITS_PER_BYTE && sh_q[7:1] != my_addr
			&& !start_ev && !stop_ev) |=> st_q == ST_IGNORE && sda_oe_n)
		else $error("foreign address was acknowledged");
	own_addr_a: assert property (@(posedge clock) disable iff (rst)
		(st_q == ST_A_ACK) |-> !sda_oe_n && sh_q[7:1] == my_addr)
		else $error("address acknowledge wrong");
	ptr_load_a: assert property (@(posedge clock) disable iff (rst)
		(st_q == ST_PTR && scl_fall && cnt_q == BITS_PER_BYTE && !start_ev && !stop_ev)
			|=> ptr_q == $past(sh_q[1:0]) ##1 st_q == ST_P_ACK)
		else $error("pointer byte not taken");
	cfg_write_a: assert property (@(posedge clock) disable iff (rst)
		(wr_q && ptr_q == PTR_CONFIG) |=> config_word == $past(wdata_q))
		else $error("config write lost");
	conv_ro_a: assert property (@(posedge clock) disable iff (rst)
		(wr_q && ptr_q == PTR_CONV) |=> $stable(cfg_q) && $stable(lo_q) && $stable(hi_q))
		else $error("write to conversion result changed a register");
	read_msb_a: assert property (@(posedge clock) disable iff (rst)
		(st_q == ST_A_ACK && rw_q && scl_fall && !start_ev && !stop_ev)
			|=> st_q == ST_RDATA && sda_oe_n == $past(rd_word[15]))
		else $error("read did not start with the high bit");
	single_end_a: assert property (@(posedge clock) disable iff (rst)
		cfg_q[CFG_SEL_LSB+2] |-> route.neg == NEG_GROUND && $onehot(route.pos_sel))
		else $error("single-ended routing wrong");
	common_pt_a: assert property (@(posedge clock) disable iff (rst)
		(cfg_q[CFG_SEL_LSB+2:CFG_SEL_LSB] inside {3'h1, 3'h2, 3'h3})
			|-> route.neg == NEG_FOURTH && !route.pos_sel[3])
		else $error("common-point routing wrong");
	stop_idle_a: assert property (@(posedge clock) disable iff (rst)
		stop_ev |=> st_q == ST_IDLE && sda_oe_n)
		else $error("stop did not release the bus");
endmodule

`default_nettype wire

//--- sim/bus_controller_model.sv
`timescale 1ns/1ps
`default_nettype none

module bus_controller_model (
	input  wire logic       clock,
	input  wire logic       sda,
	output var  logic       scl,
	output var  logic       sda_low,
	output var  logic       res_valid,
	output var  logic [7:0] res
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		res_valid = 1'b0;
		res = 8'h00;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic send_start();
		if (!scl) begin
			wait_clk(2);
			sda_low <= 1'b0;
			wait_clk(4);
			scl <= 1'b1;
			wait_clk(4);
		end
		sda_low <= 1'b1;
		wait_clk(4);
		scl <= 1'b0;
	endtask

	task automatic send_stop();
		wait_clk(2);
		sda_low <= 1'b1;
		wait_clk(4);
		scl <= 1'b1;
		wait_clk(4);
		sda_low <= 1'b0;
		wait_clk(4);
	endtask

	// Low phase 6 clocks, high 4: room for the target's 3-clock answer delay
	task automatic bit_xfer(input logic b, output logic s);
		wait_clk(2);
		sda_low <= !b;
		wait_clk(4);
		scl <= 1'b1;
		wait_clk(2);
		s = sda;
		wait_clk(2);
		scl <= 1'b0;
	endtask

	task automatic byte_xfer(input logic [7:0] d, input logic a_in, input logic is_rd);
		logic [7:0] q;
		logic       a;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(d[i], q[i]);
		end
		bit_xfer(a_in, a);
		res <= is_rd ? q : {7'h00, !a};
		res_valid <= 1'b1;
		@(posedge clock);
		res_valid <= 1'b0;
	endtask

	task automatic write_byte(input logic [7:0] d);
		byte_xfer(d, 1'b1, 1'b0);
	endtask

	task automatic read_byte(input logic last);
		byte_xfer(8'hFF, last, 1'b1);
	endtask
endmodule

`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import adc_link_pkg::*;

	logic             clock;
	logic             rst;
	logic [1:0]       strap;
	logic [15:0]      conversion_data;
	logic             scl;
	logic             ctrl_low;
	wire logic        sda;
	logic             addr_sel;
	pins_t            pins;
	logic             sda_oe_n;
	logic             sda_out;
	logic             conv_start;
	logic [15:0]      start_cnt;
	logic [15:0]      config_word;
	logic [15:0]      lo_threshold;
	logic [15:0]      hi_threshold;
	route_t           route;
	logic             res_valid;
	logic [7:0]       res;
	logic [7:0]       exp_q[$];
	logic [31:0]      seed;
	int               error_cnt;
	int               checks;

	// Open-drain wire with pull-up
	assign sda = !(ctrl_low || (!sda_oe_n && !sda_out));
	always_comb begin
		case (strap)
			2'h0: addr_sel = 1'b0;
			2'h1: addr_sel = 1'b1;
			2'h2: addr_sel = sda;
			default: addr_sel = scl;
		endcase
	end
	assign pins = {scl, sda, addr_sel};

	adc_serial_target u_dut (
		.clock(clock), .rst(rst), .pins(pins), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.conversion_data(conversion_data), .config_word(config_word),
		.lo_threshold(lo_threshold), .hi_threshold(hi_threshold),
		.conv_start(conv_start), .route(route)
	);

	bus_controller_model u_ctrl (
		.clock(clock), .sda(sda), .scl(scl), .sda_low(ctrl_low),
		.res_valid(res_valid), .res(res)
	);

	always #50 clock = ~clock;

	// Start pulses are counted so a missed or doubled pulse shows
	always @(posedge clock) begin
		if (rst) begin
			start_cnt <= 16'h0000;
		end else if (conv_start === 1'b1) begin
			start_cnt <= start_cnt + 16'h0001;
		end
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [5:0] exp_route(input int s);
		if (s >= 4) return {4'h1 << (s - 4), 2'h0};
		if (s == 0) return 6'h05;
		return {4'h1 << (s - 1), 2'h2};
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [7:0] ptr, input logic [15:0] v, input logic data);
		u_ctrl.send_start();
		exp_q.push_back(8'h01);
		u_ctrl.write_byte({ADDR_BASE, strap, 1'b0});
		exp_q.push_back(8'h01);
		u_ctrl.write_byte(ptr);
		if (data) begin
			exp_q.push_back(8'h01);
			u_ctrl.write_byte(v[15:8]);
			exp_q.push_back(8'h01);
			u_ctrl.write_byte(v[7:0]);
		end
		u_ctrl.send_stop();
	endtask

	task automatic rd_reg(input logic [15:0] v);
		u_ctrl.send_start();
		exp_q.push_back(8'h01);
		u_ctrl.write_byte({ADDR_BASE, strap, 1'b1});
		exp_q.push_back(v[15:8]);
		u_ctrl.read_byte(1'b0);
		exp_q.push_back(v[7:0]);
		u_ctrl.read_byte(1'b1);
		u_ctrl.send_stop();
	endtask

	// Each reported byte or ack is matched against the oldest note
	always @(posedge clock) begin
		if (res_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				error_cnt++;
				$display("[ERR] %0t unexpected result", $time);
			end else begin
				check({8'h00, res}, {8'h00, exp_q.pop_front()});
			end
		end
	end

	initial begin
		repeat (90000) @(posedge clock);
		error_cnt++;
		$display("[ERR] %0t run timed out", $time);
		report_and_stop();
	end

	initial begin
		logic [15:0] v;
		logic [31:0] r;
		clock = 1'b0;
		rst = 1'b1;
		strap = 2'h0;
		conversion_data = 16'h0000;
		seed = 32'h00010A48;
		error_cnt = 0;
		checks = 0;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		check(config_word, CONFIG_RESET);
		check(lo_threshold, LO_RESET);
		check(hi_threshold, HI_RESET);
		// Every strap and every input-select code; bit 15 kept low
		for (int i = 0; i < 8; i++) begin
			strap <= i[1:0];
			@(posedge clock);
			r = xs();
			v = {1'b0, i[2:0], r[11:0]};
			wr_reg(8'h01, v, 1'b1);
			check(config_word, v);
			check({10'h000, route}, {10'h000, exp_route(i)});
			rd_reg(v);
		end
		// Foreign address: no ack, following bytes ignored
		u_ctrl.send_start();
		exp_q.push_back(8'h00);
		u_ctrl.write_byte(8'hA0);
		exp_q.push_back(8'h00);
		u_ctrl.write_byte(8'h01);
		u_ctrl.send_stop();
		check(config_word, v);
		// Data written to the result pointer is acked but dropped
		r = xs();
		wr_reg(8'h00, r[15:0], 1'b1);
		check(config_word, v);
		check(lo_threshold, LO_RESET);
		check(hi_threshold, HI_RESET);
		conversion_data <= r[31:16];
		rd_reg(r[31:16]);
		for (int p = 2; p < 4; p++) begin
			r = xs();
			v = r[15:0];
			wr_reg(p[7:0], v, 1'b1);
			check(p == 2 ? lo_threshold : hi_threshold, v);
			rd_reg(v);
		end
		r = xs();
		v = r[15:0];
		conversion_data <= v;
		wr_reg(8'h00, 16'h0000, 1'b0);
		rd_reg(v);
		// Start bit with single-shot mode pulses the start output once
		check(start_cnt, 16'h0000);
		v = r[31:16] | 16'h8100;
		wr_reg(8'h01, v, 1'b1);
		check(config_word, v);
		check(start_cnt, 16'h0001);
		for (int k = 0; k < 100 && exp_q.size() != 0; k++) begin
			@(posedge clock);
		end
		if (exp_q.size() != 0) begin
			error_cnt++;
			$display("[ERR] %0t results missing", $time);
		end
		report_and_stop();
	end
endmodule

`default_nettype wire
